/* rtl/adc_sequencer_control.sv */
// Converter sequencer: triggering, scan modes, result registers
// Operation
// - Sixteen single-ended, or two pairs plus twelve
// - Per-channel range: one or two references
// - Only mux-selected channels join the sequence
// - Pair field: off, diff, odd, even, both
// - Start on command, or on a read when idle
// - Rate code sets conversion throughput
// - Direct mode: each channel once, then stop
// - Auto mode: repeat, wrap to first channel
// - Reference source internal or external
// - Finished result goes to channel register
// - Result is twelve-bit unsigned code
// - Sixteen-bit registers; software reset restores defaults
module adc_sequencer_control #(
  parameter int NUM_CH      = adc_seq_pkg::NUM_CH,
  parameter int BASE_CYCLES = adc_seq_pkg::BASE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        soft_reset,
  // Configuration
  input  wire logic        diff_mode,
  input  wire logic [2:0]  pair01_cfg,
  input  wire logic [2:0]  pair23_cfg,
  input  wire logic [15:0] mux_sel,
  input  wire logic [15:0] range_x2,
  input  wire logic        ref_external,
  input  wire logic        ref_enable,
  input  wire logic        ref_buf_enable,
  input  wire logic        adc_power,
  input  wire logic        auto_mode,
  input  wire logic [1:0]  rate_code,
  input  wire logic        auto_trigger,
  // Commands
  input  wire logic        start_conv,
  input  wire logic        read_req,
  input  wire logic [3:0]  read_chan,
  // Converter core
  input  wire logic [11:0] core_code,
  output logic [3:0]       core_chan,
  output logic             core_diff,
  output logic             core_range_x2,
  output logic             core_ref_ext,
  output logic             core_sample,
  // Host read
  output logic [15:0]      read_data,
  output logic             read_valid,
  // Status
  output logic             busy
);

  // ****************************************
  // Channel mask
  // ****************************************
  logic [15:0] chan_mask;  // Channels that take part
  logic [1:0]  pair_diff;  // Pairs running differential

  // Mask from mux bits and pair fields
  adc_chan_select u_sel (
    .mux_sel    (mux_sel),
    .pair01_cfg (pair01_cfg),
    .pair23_cfg (pair23_cfg),
    .diff_mode  (diff_mode),
    .chan_mask  (chan_mask),
    .pair_diff  (pair_diff)
  );

  // ****************************************
  // State
  // ****************************************
  typedef enum {
    ST_IDLE,
    ST_CONVERT
  } seq_state_t;

  seq_state_t       state_reg;   // Sequencer state
  seq_state_t       state_next;  // Next state
  logic [3:0]       chan_reg;    // Channel under conversion
  logic [3:0]       chan_next;   // Next channel
  logic [15:0]      data_reg [NUM_CH];   // Result registers
  logic [15:0]      data_next [NUM_CH];  // Next results
  logic [15:0]      rdata_reg;   // Read data
  logic [15:0]      rdata_next;  // Next read data
  logic             rvalid_reg;  // Read answer valid
  logic             rvalid_next; // Next read valid
  logic             slot_done;   // Conversion finished
  logic             ready;       // Analogue blocks powered
  logic             trig;        // Pass trigger

  // Conversions only meaningful once host has enabled all blocks
  assign ready = ref_enable & ref_buf_enable & adc_power;
  // Command start, or automatic start on a read request
  assign trig  = ready & (start_conv | (auto_trigger & read_req));

  // Slot timer at the chosen rate
  adc_rate_timer #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_tmr (
    .clk       (clk),
    .resetn    (resetn),
    .run       (state_reg == ST_CONVERT && !soft_reset),
    .rate_code (rate_code),
    .slot_done (slot_done)
  );

  // ****************************************
  // Channel search
  // ****************************************

  // First enabled channel at or above a start index
  function automatic logic [4:0] find_from(input logic [15:0] mask,
                                           input logic [4:0]  from);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (mask[i] && 5'(i) >= from) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : find_from

  logic [4:0] first_ch;  // Lowest enabled channel, 16 if none
  logic [4:0] next_ch;   // Next enabled after current, 16 if none

  assign first_ch = find_from(chan_mask, 5'h00);
  assign next_ch  = find_from(chan_mask, {1'b0, chan_reg} + 5'h01);

  // ****************************************
  // Sequencer next state
  // ****************************************

  // Step through the mask, store results, answer reads
  always_comb begin
    state_next  = state_reg;
    chan_next   = chan_reg;
    data_next   = data_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    core_sample = 1'b0;
    if (soft_reset) begin
      // Software reset restores every default
      state_next = ST_IDLE;
      chan_next  = 4'h0;
      for (int i = 0; i < NUM_CH; i++) begin
        data_next[i] = adc_seq_pkg::RESULT_RST;
      end
      rdata_next = adc_seq_pkg::RESULT_RST;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Launch a pass at the first enabled channel
          if (trig && first_ch != 5'h10) begin
            state_next = ST_CONVERT;
            chan_next  = first_ch[3:0];
          end
        end
        ST_CONVERT: begin
          if (slot_done) begin
            core_sample = 1'b1;
            // Zero-extended 12-bit unsigned code into own register
            data_next[chan_reg] = {4'h0, core_code};
            if (next_ch != 5'h10) begin
              chan_next = next_ch[3:0];
            end else if (auto_mode && first_ch != 5'h10 && ready) begin
              // Wrap to first enabled channel
              chan_next = first_ch[3:0];
            end else begin
              // Single pass done
              state_next = ST_IDLE;
            end
          end else if (!ready || first_ch == 5'h10) begin
            // Power removed or nothing enabled: abandon pass
            state_next = ST_IDLE;
          end
        end
        default: state_next = ST_IDLE;
      endcase
      // Registers answer reads one cycle later
      if (read_req) begin
        rdata_next  = data_reg[read_chan];
        rvalid_next = 1'b1;
      end
    end
  end

  // Register sequencer state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg  <= ST_IDLE;
      chan_reg   <= 4'h0;
      rdata_reg  <= adc_seq_pkg::RESULT_RST;
      rvalid_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        data_reg[i] <= adc_seq_pkg::RESULT_RST;
      end
    end else begin
      state_reg  <= state_next;
      chan_reg   <= chan_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      data_reg   <= data_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Core steering follows the current channel
  assign core_chan     = chan_reg;
  // Differential only on even channel of a diff pair
  assign core_diff     = (chan_reg[3:2] == 2'b00) && !chan_reg[0] &&
                         pair_diff[chan_reg[1]];
  assign core_range_x2 = range_x2[chan_reg];
  assign core_ref_ext  = ref_external;
  assign read_data     = rdata_reg;
  assign read_valid    = rvalid_reg;
  assign busy          = (state_reg == ST_CONVERT);

endmodule : adc_sequencer_control

/* shared/adc_seq_pkg.sv */
// Package of constants and types for the converter sequencer control block
package adc_seq_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CH     = 16;  // Input channel count
  localparam int RES_BITS   = 12;  // Result width
  localparam int REG_BITS   = 16;  // Host register width
  localparam int CH_W       = 4;   // Channel index width

  // ****************************************
  // Pair configuration codes
  // ****************************************
  localparam logic [2:0] PAIR_OFF      = 3'h0;  // Both inputs off
  localparam logic [2:0] PAIR_DIFF     = 3'h1;  // Even positive, odd negative
  localparam logic [2:0] PAIR_ODD_SE   = 3'h2;  // Odd input single-ended only
  localparam logic [2:0] PAIR_EVEN_SE  = 3'h3;  // Even input single-ended only
  localparam logic [2:0] PAIR_BOTH_SE  = 3'h4;  // Both single-ended

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [REG_BITS-1:0] RESULT_RST = 16'h0000;  // Data register default

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ        = 250;  // Clock rate
  localparam int BASE_RATE_KSPS = 500;  // Rate code 00 throughput
  // Cycles per conversion at rate code 00: 250e6 / 500e3
  localparam int BASE_CYCLES    = (CLK_MHZ * 1000) / BASE_RATE_KSPS;
  localparam int CNT_W          = 12;   // Wide enough for 8 x base cycles

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {
    MODE_DIRECT,
    MODE_AUTO
  } conv_mode_t;

  typedef enum logic {
    REF_INTERNAL,
    REF_EXTERNAL
  } ref_src_t;

endpackage : adc_seq_pkg

/* rtl/adc_chan_select.sv */
// Effective channel enable mask from mux selects and pair configuration
module adc_chan_select (
  // Configuration
  input  wire logic [15:0] mux_sel,
  input  wire logic [2:0]  pair01_cfg,
  input  wire logic [2:0]  pair23_cfg,
  input  wire logic        diff_mode,
  // Result
  output logic [15:0]      chan_mask,
  output logic [1:0]       pair_diff
);

  // ****************************************
  // Pair decode
  // ****************************************

  // Per pair: which of even/odd converts, and whether differential
  logic [1:0] even_on;  // Even input converts
  logic [1:0] odd_on;   // Odd input converts
  logic [2:0] cfg [2];  // Pair fields as array

  assign cfg[0] = pair01_cfg;
  assign cfg[1] = pair23_cfg;

  // Decode each pair field
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      always_comb begin
        even_on[p]   = 1'b0;
        odd_on[p]    = 1'b0;
        pair_diff[p] = 1'b0;
        if (!diff_mode) begin
          // All-single-ended arrangement ignores pair fields
          even_on[p] = 1'b1;
          odd_on[p]  = 1'b1;
        end else begin
          case (cfg[p])
            adc_seq_pkg::PAIR_DIFF: begin
              // One result, kept on even channel
              even_on[p]   = 1'b1;
              pair_diff[p] = 1'b1;
            end
            adc_seq_pkg::PAIR_ODD_SE:  odd_on[p] = 1'b1;
            adc_seq_pkg::PAIR_EVEN_SE: even_on[p] = 1'b1;
            adc_seq_pkg::PAIR_BOTH_SE: begin
              even_on[p] = 1'b1;
              odd_on[p]  = 1'b1;
            end
            default: begin
              // Off and unused codes convert nothing
              even_on[p] = 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // ****************************************
  // Final mask
  // ****************************************

  // Channel joins sequence only if its mux bit is set
  always_comb begin
    chan_mask = mux_sel;
    chan_mask[0] = mux_sel[0] & even_on[0];
    chan_mask[1] = mux_sel[1] & odd_on[0];
    chan_mask[2] = mux_sel[2] & even_on[1];
    chan_mask[3] = mux_sel[3] & odd_on[1];
  end

endmodule : adc_chan_select

/* rtl/adc_rate_timer.sv */
// Conversion slot timer: one pulse per conversion at the selected rate
module adc_rate_timer #(
  parameter int BASE_CYCLES = adc_seq_pkg::BASE_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] rate_code,
  // Status
  output logic            slot_done
);

  // ****************************************
  // Slot length
  // ****************************************

  // Code n doubles the period n times: 500/250/125/62.5 kSPS
  logic [adc_seq_pkg::CNT_W-1:0] slot_len;  // Cycles per slot
  assign slot_len = adc_seq_pkg::CNT_W'(BASE_CYCLES << rate_code);

  // ****************************************
  // Counter
  // ****************************************
  logic [adc_seq_pkg::CNT_W-1:0] cnt_reg;   // Cycles elapsed in slot
  logic [adc_seq_pkg::CNT_W-1:0] cnt_next;  // Next count

  // Count while running, restart when idle or at slot end
  always_comb begin
    cnt_next  = '0;
    slot_done = 1'b0;
    if (run) begin
      if (cnt_reg == slot_len - adc_seq_pkg::CNT_W'(1)) begin
        slot_done = 1'b1;
      end else begin
        cnt_next = cnt_reg + adc_seq_pkg::CNT_W'(1);
      end
    end
  end

  // Register the count
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : adc_rate_timer

/* sim/adc_seq_props.sv */
// Port-level assertion checker for the converter sequencer
module adc_seq_props #(
  parameter int BASE_CYCLES = 4
) (
  // Watched ports
  input wire logic        clk, resetn, soft_reset, diff_mode, ref_external, start_conv,
  input wire logic        auto_mode, ref_enable, ref_buf_enable, adc_power, read_req,
  input wire logic        read_valid, core_diff, core_range_x2, core_ref_ext, core_sample, busy,
  input wire logic [1:0]  rate_code,
  input wire logic [3:0]  core_chan,
  input wire logic [15:0] mux_sel, range_x2, read_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic        pwr_ok;            // All three enables up
  logic [15:0] gap_reg, gap_next; // Cycles since slot start
  assign pwr_ok = ref_enable && ref_buf_enable && adc_power;
  // Slot length counter, restarts on every sample
  always_comb gap_next = (!busy || core_sample) ? 16'h0001 : gap_reg + 16'h0001;
  always_ff @(posedge clk) gap_reg <= resetn ? gap_next : 16'h0001;
  sequence s_read;
    read_req && !soft_reset;
  endsequence
  sequence s_auto_slot;
    core_sample && auto_mode && pwr_ok && !soft_reset;
  endsequence
  sequence s_last_direct;
    core_sample && !auto_mode && !diff_mode && !soft_reset && ((mux_sel >> core_chan) == 16'h0001);
  endsequence
  chk_read_answer: assert property (s_read |=> read_valid && read_data[15:12] == 4'h0)
    else $error("read not answered next cycle");
  chk_valid_pulse: assert property (!read_req |=> !read_valid)
    else $error("read valid without request");
  chk_ref_follow: assert property (core_ref_ext == ref_external)
    else $error("reference select not passed on");
  chk_range_follow: assert property (busy |-> core_range_x2 == range_x2[core_chan])
    else $error("range of current channel wrong");
  chk_sample_chan: assert property (core_sample && !diff_mode |-> mux_sel[core_chan] && busy)
    else $error("unselected channel converted");
  chk_diff_even: assert property (core_sample && core_diff |-> diff_mode && core_chan < 4'h4 && !core_chan[0])
    else $error("differential result not on even channel");
  chk_slot_len: assert property (core_sample |-> gap_reg == 16'(BASE_CYCLES << rate_code))
    else $error("conversion slot length wrong");
  chk_auto_repeat: assert property (s_auto_slot |=> busy)
    else $error("auto scan stopped");
  chk_direct_stop: assert property (s_last_direct |=> !busy)
    else $error("direct pass did not stop");
  chk_start_busy: assert property (start_conv && !busy && pwr_ok && !diff_mode && (|mux_sel) && !soft_reset |=> busy)
    else $error("start command ignored");
  chk_power_gate: assert property (!busy && !pwr_ok |=> !busy)
    else $error("pass started with enables low");
endmodule : adc_seq_props
bind adc_sequencer_control adc_seq_props #(.BASE_CYCLES(BASE_CYCLES)) i_adc_seq_props (
  .clk(clk), .resetn(resetn), .soft_reset(soft_reset), .diff_mode(diff_mode),
  .ref_external(ref_external), .start_conv(start_conv), .auto_mode(auto_mode),
  .ref_enable(ref_enable), .ref_buf_enable(ref_buf_enable), .adc_power(adc_power),
  .read_req(read_req), .read_valid(read_valid), .core_diff(core_diff),
  .core_range_x2(core_range_x2), .core_ref_ext(core_ref_ext), .core_sample(core_sample),
  .busy(busy), .rate_code(rate_code), .core_chan(core_chan), .mux_sel(mux_sel),
  .range_x2(range_x2), .read_data(read_data));

/* sim/tb_adc_sequencer_control.sv */
// Self-checking bench for the converter sequencer control block
module tb_adc_sequencer_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 4; // Shortened base slot
  logic clk = 1'b0, resetn = 1'b0, soft_reset = 1'b0, diff_mode = 1'b0, ref_external = 1'b0;
  logic ref_enable = 1'b1, ref_buf_enable = 1'b1, adc_power = 1'b1, auto_mode = 1'b0;
  logic auto_trigger = 1'b0, start_conv = 1'b0, read_req = 1'b0;
  logic core_diff, core_range_x2, core_ref_ext, core_sample, read_valid, busy;
  logic [2:0]  pair01_cfg = 3'h0, pair23_cfg = 3'h0;
  logic [1:0]  rate_code = 2'h0;
  logic [3:0]  read_chan = 4'h0, core_chan;
  logic [11:0] core_code = 12'h000;
  logic [15:0] mux_sel = 16'h0000, range_x2 = 16'h0000, read_data;
  logic [15:0] model [16] = '{default: 16'h0000}; // Expected result registers
  logic [1:0]  em [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h3}; // Pair code to converted inputs
  logic [15:0] exp_rd [$]; // Expected read data
  logic [3:0]  exp_ch [$]; // Expected channel order
  int          error_cnt = 0, cmp_count = 0, cycles = 0;
  integer      seed = 32'hb9074e0b;
  adc_sequencer_control #(.BASE_CYCLES(BC)) i_adc_sequencer_control (
    .clk(clk), .resetn(resetn), .soft_reset(soft_reset), .diff_mode(diff_mode),
    .pair01_cfg(pair01_cfg), .pair23_cfg(pair23_cfg), .mux_sel(mux_sel), .range_x2(range_x2),
    .ref_external(ref_external), .ref_enable(ref_enable), .ref_buf_enable(ref_buf_enable),
    .adc_power(adc_power), .auto_mode(auto_mode), .rate_code(rate_code),
    .auto_trigger(auto_trigger), .start_conv(start_conv), .read_req(read_req),
    .read_chan(read_chan), .core_code(core_code), .core_chan(core_chan), .core_diff(core_diff),
    .core_range_x2(core_range_x2), .core_ref_ext(core_ref_ext), .core_sample(core_sample),
    .read_data(read_data), .read_valid(read_valid), .busy(busy));
  always #2 clk = ~clk;
  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Hang guard
  always @(negedge clk) if (++cycles > 20000) begin
    error_cnt++;
    stop_test();
  end
  // Output monitor: reads and conversion slots
  always @(negedge clk) begin
    if (read_valid) check(read_data, exp_rd.size() ? exp_rd.pop_front() : 16'hxxxx);
    if (core_sample) begin
      check({12'h000, core_chan}, exp_ch.size() ? {12'h000, exp_ch[0]} : 16'hxxxx);
      check({15'h0000, core_diff}, {15'h0000, diff_mode && core_chan < 4'h4 && !core_chan[0] && ((core_chan[1] ? pair23_cfg : pair01_cfg) == 3'h1)});
      core_code = 12'($random(seed));
      if (exp_ch.size()) model[exp_ch.pop_front()] = {4'h0, core_code};
    end
  end
  // Consecutive reads, request held high throughout
  task automatic rd(input int first, input int n);
    for (int k = first; k < first + n; k++) begin
      exp_rd.push_back(model[k]);
      read_chan = 4'(k);
      read_req = 1'b1;
      @(negedge clk);
    end
    read_req = 1'b0;
    repeat (2) @(negedge clk);
  endtask : rd
  task automatic expect_mask(input logic [15:0] m);
    for (int k = 0; k < 16; k++) if (m[k]) exp_ch.push_back(4'(k));
  endtask : expect_mask
  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
  endtask : wait_idle
  // One triggered pass
  task automatic pass(input logic [15:0] m);
    expect_mask(m);
    start_conv = 1'b1;
    @(negedge clk) start_conv = 1'b0;
    wait_idle();
    check(16'(exp_ch.size()), 16'h0000);
  endtask : pass
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    rd(0, 16);
    $display("reset values done");
    for (int r = 0; r < 4; r++) begin
      rate_code = 2'(r);
      ref_external = r[0];
      range_x2 = 16'($random(seed));
      mux_sel = 16'($random(seed)) | 16'h0001;
      pass(mux_sel);
      rd(0, 16);
    end
    $display("direct rates done");
    diff_mode = 1'b1;
    mux_sel = 16'h800f;
    for (int p = 0; p < 5; p++) begin
      pair01_cfg = 3'(p);
      pair23_cfg = 3'(4 - p);
      pass({12'h800, em[4 - p], em[p]});
      rd(0, 4);
    end
    $display("pair configs done");
    diff_mode = 1'b0;
    auto_mode = 1'b1;
    mux_sel = 16'h0124;
    repeat (3) expect_mask(mux_sel);
    start_conv = 1'b1;
    @(negedge clk) start_conv = 1'b0;
    for (int i = 0; i < 2000 && exp_ch.size() > 0; i++) @(negedge clk);
    adc_power = 1'b0;
    wait_idle();
    ref_enable = 1'b0;
    adc_power = 1'b1;
    start_conv = 1'b1;
    @(negedge clk) start_conv = 1'b0;
    repeat (3) @(negedge clk);
    check({15'h0000, busy}, 16'h0000);
    ref_enable = 1'b1;
    auto_mode = 1'b0;
    rd(0, 16);
    soft_reset = 1'b1;
    @(negedge clk) soft_reset = 1'b0;
    foreach (model[k]) model[k] = 16'h0000;
    rd(0, 16);
    $display("auto scan and soft reset done");
    auto_trigger = 1'b1;
    mux_sel = 16'h0040;
    repeat (2) begin
      expect_mask(mux_sel);
      rd(6, 1);
      wait_idle();
    end
    auto_trigger = 1'b0;
    rd(6, 1);
    $display("auto trigger done");
    stop_test();
  end
endmodule : tb_adc_sequencer_control
